/* File: verilog/sflash_pkg.sv */
// Shared constants for the serial flash device end and its host end.
// Assumes one system clock at CLK_MHZ; all times become counts of that clock.
package sflash_pkg;
	// ****************************************
	// Clock
	// ****************************************
	localparam int CLK_MHZ = 10;
	localparam int CLK_PERIOD_NS = 100;
	// ****************************************
	// Times, as printed, and derived cycle counts
	// ****************************************
	localparam int T_WP_US = 1;
	localparam int T_LOCK_US = 100;
	localparam int T_EUDPD_US = 4;
	localparam int WAKE_SELECT_LOW_TIME_NS = 20;
	localparam int T_XUDPD_US = 180;
	localparam int T_EDPD_US = 2;
	localparam int T_RDPD_US = 35;
	localparam int PAGE_BUFFER_MOVE_TIME_US = 200;
	localparam int T_COMP_US = 200;
	localparam int T_EP_MS = 35;
	localparam int T_P_MS = 4;
	localparam int T_PE_MS = 35;
	localparam int T_OTPP_US = 500;
	localparam int T_VCSL_US = 85;
	localparam int T_PUW_MS = 3;
	localparam int WP_CYC = T_WP_US * CLK_MHZ;
	localparam int LOCK_CYC = T_LOCK_US * CLK_MHZ;
	localparam int EUDPD_CYC = T_EUDPD_US * CLK_MHZ;
	localparam int WAKE_CYC = (WAKE_SELECT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XUDPD_CYC = T_XUDPD_US * CLK_MHZ;
	localparam int EDPD_CYC = T_EDPD_US * CLK_MHZ;
	localparam int RDPD_CYC = T_RDPD_US * CLK_MHZ;
	localparam int XFR_CYC = PAGE_BUFFER_MOVE_TIME_US * CLK_MHZ;
	localparam int COMP_CYC = T_COMP_US * CLK_MHZ;
	localparam int EP_CYC = T_EP_MS * 1000 * CLK_MHZ;
	localparam int P_CYC = T_P_MS * 1000 * CLK_MHZ;
	localparam int PE_CYC = T_PE_MS * 1000 * CLK_MHZ;
	localparam int OTPP_CYC = T_OTPP_US * CLK_MHZ;
	localparam int VCSL_CYC = T_VCSL_US * CLK_MHZ;
	localparam int PUW_CYC = T_PUW_MS * 1000 * CLK_MHZ;
	// ****************************************
	// Serial clock limits in MHz and operation timer width
	// ****************************************
	localparam int F_GEN_MHZ = 70;
	localparam int F_CAR1_MHZ = 85;
	localparam int F_CAR2_MHZ = 50;
	localparam int F_CAR3_MHZ = 15;
	localparam int F_CAR4_MHZ = 104;
	localparam int TIMER_W = 19;
	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] OP_READ_FAST = 8'h0b;
	localparam logic [7:0] OP_READ_SLOW = 8'h03;
	localparam logic [7:0] OP_READ_LP = 8'h01;
	localparam logic [7:0] OP_READ_HS = 8'h1b;
	localparam logic [7:0] OP_STATUS = 8'hd7;
	localparam logic [7:0] OP_DPD = 8'hb9;
	localparam logic [7:0] OP_RESUME = 8'hab;
	localparam logic [7:0] OP_UDPD = 8'h79;
	localparam logic [7:0] OP_XFR = 8'h53;
	localparam logic [7:0] OP_COMP = 8'h60;
	localparam logic [7:0] OP_ERPG = 8'h83;
	localparam logic [7:0] OP_PROG = 8'h88;
	localparam logic [7:0] OP_ERASE = 8'h81;
	localparam logic [7:0] OP_OTP = 8'h9b;
	localparam logic [7:0] OP_LOCK = 8'h34;
	// ****************************************
	// Status byte fields
	// ****************************************
	localparam int ST_READY = 7;
	localparam int ST_LOCK = 5;
	localparam int ST_PROT = 4;
	localparam int ST_OTP = 3;
	localparam logic [7:0] DATA_RESET = 8'h00;
endpackage : sflash_pkg

/* File: verilog/sflash_if.sv */
// Four-wire serial link between the host end and the device end.
// Assumes both ends run on the same ref_clk; the host makes sck.
`timescale 1ns/1ps
interface sflash_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	modport dev (
		input cs_n,
		input sck,
		input mosi,
		output miso,
		output miso_oe
	);
	modport host (
		output cs_n,
		output sck,
		output mosi,
		input miso,
		input miso_oe
	);
endinterface : sflash_if

/* File: verilog/sflash_dev.sv */
// Device end of the serial flash link: shifter, command timing and power states.
// Assumes sck, cs_n and mosi are synchronous to ref_clk and sck is at most ref_clk/2.
//
// Functional notes
// - Launch on sck fall, sample on rise.
// - Host captures on the following sck fall.
// - Host changes its output on rising edges.
// - Host keeps sck under per-read limits.
// - Write protect follows its pin within 1us.
// - Lockdown freeze done within 100us of deselect.
// - Ultra-deep power-down entered within 4us.
// - Wake needs select low at least 20ns.
// - Ready 180us after ultra-deep wake begins.
// - Deep power-down entered within 2us.
// - Resume leaves deep power-down within 35us.
// - Page transfer or compare within 200us.
// - Erase-program 35ms, program 4ms, erase 35ms.
// - Security register program within 500us.
// - Output valid while sck still low.
// - Full-cycle capture holds up to 85MHz.
// - Host waits 85us, program after 3ms.
// - Host keeps select high through reset.
`timescale 1ns/1ps
module sflash_dev #(
	parameter int unsigned EP_CYC = sflash_pkg::EP_CYC,
	parameter int unsigned P_CYC = sflash_pkg::P_CYC,
	parameter int unsigned PE_CYC = sflash_pkg::PE_CYC,
	parameter int unsigned OTPP_CYC = sflash_pkg::OTPP_CYC
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Serial link
	sflash_if.dev link,
	// Protect pin
	input wire logic wp_n,
	// Status
	output logic busy,
	output logic prot,
	output logic lock,
	output logic otp_done,
	output logic dpd,
	output logic udpd
);
	localparam int TW = sflash_pkg::TIMER_W;

	// ****************************************
	// Parameter check
	// ****************************************
	if (EP_CYC < 2 || P_CYC < 2 || PE_CYC < 2 || OTPP_CYC < 2 ||
		EP_CYC >= (1 << TW) || PE_CYC >= (1 << TW) ||
		P_CYC >= (1 << TW) || OTPP_CYC >= (1 << TW)) begin : g_bad
		$error("sflash_dev: operation counts must be 2 to 2**TIMER_W-1");
	end

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic [TW-1:0] op_cycles(input logic [7:0] op);
		logic [TW-1:0] c;
		c = '0;
		unique case (op)
			sflash_pkg::OP_DPD: c = TW'(sflash_pkg::EDPD_CYC);
			sflash_pkg::OP_RESUME: c = TW'(sflash_pkg::RDPD_CYC);
			sflash_pkg::OP_UDPD: c = TW'(sflash_pkg::EUDPD_CYC);
			sflash_pkg::OP_XFR: c = TW'(sflash_pkg::XFR_CYC);
			sflash_pkg::OP_COMP: c = TW'(sflash_pkg::COMP_CYC);
			sflash_pkg::OP_ERPG: c = TW'(EP_CYC);
			sflash_pkg::OP_PROG: c = TW'(P_CYC);
			sflash_pkg::OP_ERASE: c = TW'(PE_CYC);
			sflash_pkg::OP_OTP: c = TW'(OTPP_CYC);
			sflash_pkg::OP_LOCK: c = TW'(sflash_pkg::LOCK_CYC);
			default: c = '0;
		endcase
		return c;
	endfunction : op_cycles

	function automatic logic is_write(input logic [7:0] op);
		return op == sflash_pkg::OP_ERPG || op == sflash_pkg::OP_PROG ||
			op == sflash_pkg::OP_ERASE || op == sflash_pkg::OP_OTP;
	endfunction : is_write

	function automatic logic is_read(input logic [7:0] op);
		return op == sflash_pkg::OP_READ_FAST || op == sflash_pkg::OP_READ_SLOW ||
			op == sflash_pkg::OP_READ_LP || op == sflash_pkg::OP_READ_HS;
	endfunction : is_read

	// ****************************************
	// State
	// ****************************************
	logic sck_p_q;
	logic mosi_p_q;
	logic cs_p_q;
	logic [7:0] sh_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] op_q;
	logic [7:0] run_q;
	logic [TW-1:0] timer_q;
	logic [7:0] tx_q;
	logic [2:0] tx_cnt_q;
	logic [7:0] data_q;
	logic so_q;
	logic prot_q;
	logic lock_q;
	logic otp_q;
	logic dpd_q;
	logic udpd_q;

	// ****************************************
	// Edge and command decode
	// ****************************************
	wire sel = !link.cs_n;
	wire rise = sel && !sck_p_q && link.sck;
	wire fall = sel && sck_p_q && !link.sck;
	wire cs_start = cs_p_q && sel;
	wire cs_end = !cs_p_q && link.cs_n;
	wire cmd_done = bit_cnt_q == 4'h8;
	wire last_in = rise && bit_cnt_q == 4'h7;
	wire [7:0] op_in = {sh_q[6:0], mosi_p_q};
	wire is_busy = timer_q != '0;
	wire finish = timer_q == TW'(1);
	wire rd_stat = op_q == sflash_pkg::OP_STATUS;
	wire rd_any = cmd_done && (rd_stat || is_read(op_q)) && !dpd_q && !udpd_q;
	wire wr_ok = !prot_q && !(op_q == sflash_pkg::OP_OTP && otp_q);
	wire accept = cs_end && cmd_done && !is_busy && !udpd_q &&
		(!dpd_q || op_q == sflash_pkg::OP_RESUME) &&
		(!is_write(op_q) || wr_ok);
	wire [TW-1:0] load_cyc = op_cycles(op_q);
	wire wake = cs_start && udpd_q;
	wire [7:0] status;
	assign status[sflash_pkg::ST_READY] = !is_busy;
	assign status[6] = 1'b0;
	assign status[sflash_pkg::ST_LOCK] = lock_q;
	assign status[sflash_pkg::ST_PROT] = prot_q;
	assign status[sflash_pkg::ST_OTP] = otp_q;
	assign status[2:0] = 3'h0;
	wire [7:0] next_byte = rd_stat ? status : data_q;

	// ****************************************
	// Input shifter
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sck_p_q <= 1'b0;
			mosi_p_q <= 1'b0;
			cs_p_q <= 1'b1;
			sh_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			op_q <= 8'h00;
		end else if (ce) begin
			sck_p_q <= link.sck;
			mosi_p_q <= link.mosi;
			cs_p_q <= link.cs_n;
			if (!sel) begin
				bit_cnt_q <= 4'h0;
			end else if (rise && !cmd_done) begin
				sh_q <= op_in;
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			if (last_in) begin
				op_q <= op_in;
			end
		end
	end

	// ****************************************
	// Output shifter
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_q <= 8'h00;
			tx_cnt_q <= 3'h0;
			so_q <= 1'b0;
			data_q <= sflash_pkg::DATA_RESET;
		end else if (ce) begin
			if (!sel) begin
				tx_cnt_q <= 3'h0;
			end else if (fall && rd_any) begin
				tx_cnt_q <= tx_cnt_q + 3'h1;
				if (tx_cnt_q == 3'h0) begin
					so_q <= next_byte[7];
					tx_q <= {next_byte[6:0], 1'b0};
					data_q <= data_q + 8'h01;
				end else begin
					so_q <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

	assign link.miso = so_q;
	assign link.miso_oe = sel && rd_any;

	// ****************************************
	// Operation timer and power states
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_q <= '0;
			run_q <= 8'h00;
			lock_q <= 1'b0;
			otp_q <= 1'b0;
			dpd_q <= 1'b0;
			udpd_q <= 1'b0;
		end else if (ce) begin
			if (wake) begin
				udpd_q <= 1'b0;
				timer_q <= TW'(sflash_pkg::XUDPD_CYC - 1);
				run_q <= 8'h00;
			end else if (accept && load_cyc != '0) begin
				// The select edge is seen one cycle late, so one count less.
				timer_q <= load_cyc - TW'(1);
				run_q <= op_q;
			end else if (is_busy) begin
				timer_q <= timer_q - TW'(1);
			end
			if (finish) begin
				unique case (run_q)
					sflash_pkg::OP_DPD: dpd_q <= 1'b1;
					sflash_pkg::OP_RESUME: dpd_q <= 1'b0;
					sflash_pkg::OP_UDPD: udpd_q <= 1'b1;
					sflash_pkg::OP_LOCK: lock_q <= 1'b1;
					sflash_pkg::OP_OTP: otp_q <= 1'b1;
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Write protect
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prot_q <= 1'b0;
		end else if (ce) begin
			prot_q <= !wp_n;
		end
	end

	assign busy = is_busy;
	assign prot = prot_q;
	assign lock = lock_q;
	assign otp_done = otp_q;
	assign dpd = dpd_q;
	assign udpd = udpd_q;
endmodule : sflash_dev

/* File: verilog/sflash_host.sv */
// Host end of the serial flash link: makes sck, sends one command, reads bytes.
// Assumes the device end on the same ref_clk; waits out each operation.
`timescale 1ns/1ps
module sflash_host #(
	parameter int unsigned EP_CYC = sflash_pkg::EP_CYC,
	parameter int unsigned P_CYC = sflash_pkg::P_CYC,
	parameter int unsigned PE_CYC = sflash_pkg::PE_CYC,
	parameter int unsigned OTPP_CYC = sflash_pkg::OTPP_CYC,
	parameter int unsigned PUW_CYC = sflash_pkg::PUW_CYC
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Command
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_op,
	input wire logic [3:0] cmd_rd_bytes,
	output logic cmd_ready,
	// Answer
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	// Serial link
	sflash_if.host link
);
	localparam int TW = sflash_pkg::TIMER_W;

	// ****************************************
	// Parameter check
	// ****************************************
	if (EP_CYC == 0 || P_CYC == 0 || PE_CYC == 0 || OTPP_CYC == 0 ||
		PUW_CYC < sflash_pkg::VCSL_CYC || PUW_CYC >= (1 << TW) ||
		EP_CYC >= (1 << TW) || PE_CYC >= (1 << TW) ||
		P_CYC >= (1 << TW) || OTPP_CYC >= (1 << TW)) begin : g_bad
		$error("sflash_host: counts out of range");
	end

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic [3:0] half_of(input int f_mhz);
		int h;
		h = (sflash_pkg::CLK_MHZ + 2 * f_mhz - 1) / (2 * f_mhz);
		return (h < 1) ? 4'h1 : 4'(h);
	endfunction : half_of

	function automatic logic [3:0] op_half(input logic [7:0] op);
		logic [3:0] h;
		h = half_of(sflash_pkg::F_GEN_MHZ);
		unique case (op)
			sflash_pkg::OP_READ_FAST: h = half_of(sflash_pkg::F_CAR1_MHZ);
			sflash_pkg::OP_READ_SLOW: h = half_of(sflash_pkg::F_CAR2_MHZ);
			sflash_pkg::OP_READ_LP: h = half_of(sflash_pkg::F_CAR3_MHZ);
			sflash_pkg::OP_READ_HS: h = half_of(sflash_pkg::F_CAR4_MHZ);
			default: h = half_of(sflash_pkg::F_GEN_MHZ);
		endcase
		return h;
	endfunction : op_half

	function automatic logic [TW-1:0] op_wait(input logic [7:0] op);
		logic [TW-1:0] c;
		c = TW'(1);
		unique case (op)
			sflash_pkg::OP_DPD: c = TW'(sflash_pkg::EDPD_CYC);
			sflash_pkg::OP_RESUME: c = TW'(sflash_pkg::RDPD_CYC);
			sflash_pkg::OP_UDPD: c = TW'(sflash_pkg::EUDPD_CYC);
			sflash_pkg::OP_XFR: c = TW'(sflash_pkg::XFR_CYC);
			sflash_pkg::OP_COMP: c = TW'(sflash_pkg::COMP_CYC);
			sflash_pkg::OP_ERPG: c = TW'(EP_CYC);
			sflash_pkg::OP_PROG: c = TW'(P_CYC);
			sflash_pkg::OP_ERASE: c = TW'(PE_CYC);
			sflash_pkg::OP_OTP: c = TW'(OTPP_CYC);
			sflash_pkg::OP_LOCK: c = TW'(sflash_pkg::LOCK_CYC);
			default: c = TW'(1);
		endcase
		return c;
	endfunction : op_wait

	typedef enum logic [2:0] {
		ST_BOOT = 3'h0,
		ST_IDLE = 3'h1,
		ST_SEL = 3'h2,
		ST_SHIFT = 3'h3,
		ST_WAIT = 3'h4
	} state_t;

	// ****************************************
	// State
	// ****************************************
	state_t state_q;
	logic [TW-1:0] cnt_q;
	logic [TW-1:0] boot_q;
	logic [3:0] div_q;
	logic [3:0] half_q;
	logic [7:0] op_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic [7:0] falls_q;
	logic [7:0] last_q;
	logic asleep_q;
	logic cs_n_q;
	logic sck_q;
	logic mosi_q;
	logic [7:0] rd_data_q;
	logic rd_valid_q;
	logic done_q;

	wire pe_op = cmd_op == sflash_pkg::OP_ERPG || cmd_op == sflash_pkg::OP_PROG ||
		cmd_op == sflash_pkg::OP_ERASE || cmd_op == sflash_pkg::OP_OTP;
	wire pe_ok = boot_q == TW'(PUW_CYC);
	wire tick = div_q == half_q;
	wire cap = tick && sck_q && falls_q >= 8'h08;
	wire [7:0] rx_nx = {rx_q[6:0], link.miso};
	wire [7:0] falls_nx = falls_q + 8'h01;
	wire [7:0] last_nx = 8'(8 + 8 * cmd_rd_bytes);

	assign cmd_ready = state_q == ST_IDLE && (!pe_op || pe_ok);

	// ****************************************
	// Power-up counter
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			boot_q <= '0;
		end else if (ce && !pe_ok) begin
			boot_q <= boot_q + TW'(1);
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_BOOT;
			cnt_q <= '0;
			div_q <= 4'h1;
			half_q <= 4'h1;
			op_q <= 8'h00;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			falls_q <= 8'h00;
			last_q <= 8'h00;
			asleep_q <= 1'b0;
			cs_n_q <= 1'b1;
			sck_q <= 1'b0;
			mosi_q <= 1'b0;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
			unique case (state_q)
				ST_BOOT: begin
					if (boot_q >= TW'(sflash_pkg::VCSL_CYC)) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (cmd_valid && cmd_ready) begin
						state_q <= ST_SEL;
						cs_n_q <= 1'b0;
						op_q <= cmd_op;
						mosi_q <= cmd_op[7];
						sh_q <= {cmd_op[6:0], 1'b0};
						half_q <= op_half(cmd_op);
						last_q <= last_nx;
						falls_q <= 8'h00;
						cnt_q <= TW'(sflash_pkg::WAKE_CYC);
					end
				end
				ST_SEL: begin
					cnt_q <= cnt_q - TW'(1);
					div_q <= 4'h1;
					if (cnt_q == TW'(1)) begin
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					div_q <= tick ? 4'h1 : div_q + 4'h1;
					if (tick && !sck_q) begin
						sck_q <= 1'b1;
						mosi_q <= sh_q[7];
						sh_q <= {sh_q[6:0], 1'b0};
					end
					if (tick && sck_q) begin
						sck_q <= 1'b0;
						falls_q <= falls_nx;
					end
					if (cap) begin
						rx_q <= rx_nx;
					end
					if (cap && falls_q[2:0] == 3'h7) begin
						rd_data_q <= rx_nx;
						rd_valid_q <= 1'b1;
					end
					if (tick && sck_q && falls_nx == last_q) begin
						state_q <= ST_WAIT;
						cs_n_q <= 1'b1;
						mosi_q <= 1'b0;
						asleep_q <= op_q == sflash_pkg::OP_UDPD;
						cnt_q <= asleep_q ? TW'(sflash_pkg::XUDPD_CYC) : op_wait(op_q);
					end
				end
				ST_WAIT: begin
					cnt_q <= cnt_q - TW'(1);
					if (cnt_q == TW'(1)) begin
						state_q <= ST_IDLE;
						done_q <= 1'b1;
					end
				end
				default: state_q <= ST_BOOT;
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sck = sck_q;
	assign link.mosi = mosi_q;
	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign done = done_q;
endmodule : sflash_host

/* File: sim/sflash_sva.sv */
// Checker for the four-wire serial link between the host end and the device end.
// Assumes it is instantiated beside the link interface, on the same ref_clk and rst.
`timescale 1ns/1ps
module sflash_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	// ****************************************
	// Edge counters for one frame
	// ****************************************
	logic sck_q;
	logic cs_q;
	logic [7:0] rise_q;
	logic [7:0] fall_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			rise_q <= 8'h00;
			fall_q <= 8'h00;
		end else begin
			sck_q <= sck;
			cs_q <= cs_n;
			rise_q <= (!cs_n && cs_q) ? 8'h00 : rise_q + {7'h00, sck && !sck_q};
			fall_q <= (!cs_n && cs_q) ? 8'h00 : fall_q + {7'h00, !sck && sck_q};
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_miso_low;
		(!cs_n && $past(cs_n) == 1'b0 && miso_oe && $past(miso_oe) && !sck) |-> $stable(miso);
	endproperty
	a_miso_low: assert property (p_miso_low) else $error("miso moved in sck low phase");
	property p_mosi_rise;
		(!cs_n && !$past(cs_n) && $changed(mosi)) |-> $rose(sck);
	endproperty
	a_mosi_rise: assert property (p_mosi_rise) else $error("mosi moved off a rise");
	property p_sck_idle;
		cs_n |-> (!sck && !mosi);
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("link not idle");
	property p_sel_start;
		$fell(cs_n) |-> (!sck && !$past(sck));
	endproperty
	a_sel_start: assert property (p_sel_start) else $error("sck high at select");
	property p_oe_sel;
		miso_oe |-> (!cs_n && rise_q >= 8'h08);
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("miso driven before opcode");
	property p_frame_bits;
		$rose(cs_n) |=> (rise_q == fall_q && rise_q[2:0] == 3'h0 && rise_q != 8'h00);
	endproperty
	a_frame_bits: assert property (p_frame_bits) else $error("frame not whole bytes");
	property p_sck_rate;
		(!cs_n && sck) |=> !sck;
	endproperty
	a_sck_rate: assert property (p_sck_rate) else $error("sck high too long");
	property p_oe_hold;
		(miso_oe && !cs_n) |=> (miso_oe || cs_n);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("miso released in frame");
endmodule : sflash_sva

/* File: sim/tb_serial_flash_bus_timing.sv */
// Testbench joining the host end and the device end through the link interface.
// Assumes shortened operation counts, set alike on both ends.
`timescale 1ns/1ps
module tb_serial_flash_bus_timing;
	localparam int unsigned EP_N = 300;
	localparam int unsigned P_N = 200;
	localparam int unsigned PE_N = 300;
	localparam int unsigned OTPP_N = 100;
	logic ref_clk, rst, wp_n, cmd_valid, cmd_ready, rd_valid, done;
	logic busy, prot, lock, otp_done, dpd, udpd, prev_sck, prev_mosi;
	logic [7:0] cmd_op, rd_data, mon_op;
	logic [3:0] cmd_rd_bytes;
	logic [7:0] rx [16];
	int num_errors, compares, bcnt, nrx, nbit;
	// ****************************************
	// Design and checker
	// ****************************************
	sflash_if i_sflash_if();
	sflash_dev #(.EP_CYC(EP_N), .P_CYC(P_N), .PE_CYC(PE_N), .OTPP_CYC(OTPP_N)) i_sflash_dev (
		.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .link(i_sflash_if.dev), .wp_n(wp_n),
		.busy(busy), .prot(prot), .lock(lock), .otp_done(otp_done), .dpd(dpd), .udpd(udpd));
	sflash_host #(.EP_CYC(EP_N), .P_CYC(P_N), .PE_CYC(PE_N), .OTPP_CYC(OTPP_N), .PUW_CYC(900))
		i_sflash_host (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_rd_bytes(cmd_rd_bytes), .cmd_ready(cmd_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .done(done), .link(i_sflash_if.host));
	sflash_sva i_sflash_sva (.ref_clk(ref_clk), .rst(rst), .cs_n(i_sflash_if.cs_n),
		.sck(i_sflash_if.sck), .mosi(i_sflash_if.mosi), .miso(i_sflash_if.miso),
		.miso_oe(i_sflash_if.miso_oe));
	// ****************************************
	// Clock, wire monitor and tasks
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Collects the first eight bits sampled at sck rises of each frame.
	always @(negedge ref_clk) begin
		if (i_sflash_if.cs_n !== 1'b0) nbit = 0;
		else if (i_sflash_if.sck && !prev_sck && nbit < 8) begin
			mon_op = {mon_op[6:0], prev_mosi};
			nbit++;
		end
		prev_sck = i_sflash_if.sck;
		prev_mosi = i_sflash_if.mosi;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic complete_run();
		$display("Compares: %0d, errors: %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	// Sends one command, collects bytes and counts busy cycles until done.
	task automatic send(input logic [7:0] op, input logic [3:0] n);
		int k;
		k = 0;
		nrx = 0;
		bcnt = 0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_rd_bytes <= n;
		do begin @(negedge ref_clk); k++; end while (cmd_ready !== 1'b1 && k < 2000);
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
			if (busy === 1'b1) bcnt++;
			if (rd_valid === 1'b1 && nrx < 16) begin
				rx[nrx] = rd_data;
				nrx++;
			end
		end while (done !== 1'b1 && k < 5000);
		chk("done", 1, done);
		chk("opcode on wire", op, mon_op);
	endtask : send
	task automatic status(input logic [7:0] exp);
		send(sflash_pkg::OP_STATUS, 4'h1);
		chk("status", exp, rx[0]);
	endtask : status
	task automatic t_reads();
		int i;
		logic [7:0] ops [4];
		ops = '{sflash_pkg::OP_READ_FAST, sflash_pkg::OP_READ_SLOW, sflash_pkg::OP_READ_LP,
			sflash_pkg::OP_READ_HS};
		for (i = 0; i < 4; i++) begin
			send(ops[i], 4'h2);
			chk("read bytes", 2, nrx);
			chk("read byte a", 2 * i, rx[0]);
			chk("read byte b", 2 * i + 1, rx[1]);
		end
	endtask : t_reads
	task automatic t_timed();
		int i;
		logic [7:0] ops [7];
		int lim [7];
		ops = '{sflash_pkg::OP_XFR, sflash_pkg::OP_COMP, sflash_pkg::OP_ERPG, sflash_pkg::OP_PROG,
			sflash_pkg::OP_ERASE, sflash_pkg::OP_OTP, sflash_pkg::OP_LOCK};
		lim = '{sflash_pkg::XFR_CYC, sflash_pkg::COMP_CYC, EP_N, P_N, PE_N, OTPP_N,
			sflash_pkg::LOCK_CYC};
		for (i = 0; i < 7; i++) begin
			send(ops[i], 4'h0);
			chk("busy span", 1, bcnt <= lim[i] && bcnt + 3 >= lim[i]);
		end
		chk("lock", 1, lock);
		chk("otp done", 1, otp_done);
		send(sflash_pkg::OP_OTP, 4'h0);
		chk("second otp", 0, bcnt);
		status(8'ha8);
	endtask : t_timed
	task automatic t_power();
		send(sflash_pkg::OP_DPD, 4'h0);
		chk("dpd entry", 1, dpd === 1'b1 && bcnt <= sflash_pkg::EDPD_CYC);
		send(sflash_pkg::OP_LOCK, 4'h0);
		chk("busy in dpd", 0, bcnt);
		send(sflash_pkg::OP_RESUME, 4'h0);
		chk("resume", 1, dpd === 1'b0 && bcnt <= sflash_pkg::RDPD_CYC);
		send(sflash_pkg::OP_UDPD, 4'h0);
		chk("udpd entry", 1, udpd === 1'b1 && bcnt <= sflash_pkg::EUDPD_CYC);
		send(sflash_pkg::OP_STATUS, 4'h1);
		chk("wake", 1, udpd === 1'b0 && bcnt > 0 && bcnt <= sflash_pkg::XUDPD_CYC);
		status(8'ha8);
	endtask : t_power
	task automatic set_wp(input logic v, input logic exp_prot);
		int k;
		k = 0;
		@(posedge ref_clk);
		wp_n <= v;
		do begin @(negedge ref_clk); k++; end while (prot !== exp_prot && k < 100);
		chk("protect delay", 1, k <= sflash_pkg::WP_CYC);
	endtask : set_wp
	task automatic t_protect();
		set_wp(1'b0, 1'b1);
		send(sflash_pkg::OP_PROG, 4'h0);
		chk("program while protected", 0, bcnt);
		status(8'hb8);
		set_wp(1'b1, 1'b0);
	endtask : t_protect
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		rst = 1'b1;
		wp_n = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_rd_bytes = 4'h0;
		num_errors = 0;
		compares = 0;
		nbit = 0;
		prev_sck = 1'b0;
		prev_mosi = 1'b0;
		mon_op = 8'h00;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reads();
		status(8'h80);
		t_timed();
		t_power();
		t_protect();
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		num_errors++;
		complete_run();
	end
endmodule : tb_serial_flash_bus_timing
